// file: core/gp_ports.sv
/*
 Port latches, drive mode registers and global control for Port0, Port2 and
 Port3, on the core's special-function register bus.
 Assumes pins arrive synchronous to mclk_i and the bus read is combinational.
*/
// Summary of operation
// - Latch bit 0 drives pin low, 1 drives high subject to drive mode.
// - Port0 latch 1 with open-drain mode leaves the pin floating.
// - Port2 latch 1 with open-drain mode floats the pin.
// - Port3 latch 1 with open-drain mode floats the pin.
// - With input enable off, plain port reads return all zeros.
// - With input enable on, plain port reads return pin levels, not latches.
// - Port0 mode bit n at 0 selects open-drain for pin n.
// - Port0 mode bit n at 1 selects push-pull for pin n.
// - Port2 mode bits 7 and 6 read zero and ignore writes.
// - Port3 bits 7 to 1 of latch and mode read zero, ignore writes.
// - Port2 mode bits 5 to 0: 0 open-drain, 1 push-pull.
// - Port3 mode bit 0: 0 open-drain, 1 push-pull.
// - Input enable is bit 6 of global control; 0 disables input sensing.
// - Weak pullup on only if not disabled, open-drain and latch one.
// - Read-modify-write reads the latch instead of the pin.
`timescale 1ns/10ps
`default_nettype none
`include "gp_map.svh"

module gp_ports (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Register bus
   input wire gp_pkg::gp_sfr_req_s sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   // Port0 pins
   input wire logic [7:0] port0_pad_i,
   output logic [7:0] port0_pad_o,
   output logic [7:0] port0_pad_oe_o,
   output logic [7:0] port0_pullup_o,
   // Port2 pins
   input wire logic [5:0] port2_pad_i,
   output logic [5:0] port2_pad_o,
   output logic [5:0] port2_pad_oe_o,
   output logic [5:0] port2_pullup_o,
   // Port3 pin
   input wire logic port3_pad_i,
   output logic port3_pad_o,
   output logic port3_pad_oe_o,
   output logic port3_pullup_o,
   // Global control taps
   output logic sysclk_out_en_o
);
   import gp_pkg::*;

   logic [7:0] p0_latch_r, p0_latch_nxt, p0_mode_r, p0_mode_nxt;
   logic [5:0] p2_latch_r, p2_latch_nxt, p2_mode_r, p2_mode_nxt;
   logic p3_latch_r, p3_latch_nxt, p3_mode_r, p3_mode_nxt;
   logic pullup_dis_r, pullup_dis_nxt;
   logic input_en_r, input_en_nxt;
   logic sysclk_en_r, sysclk_en_nxt;
   logic [7:0] p0_read, p2_read, p3_read;
   logic [7:0] p0_sample_r, p0_sample_nxt;
   logic [5:0] p2_sample_r, p2_sample_nxt;
   logic p3_sample_r, p3_sample_nxt;
   gp_byte_t rdata;
   logic hit;

   // Register writes; unimplemented bits are simply not stored
   always_comb begin
      p0_latch_nxt = p0_latch_r;
      p0_mode_nxt = p0_mode_r;
      p2_latch_nxt = p2_latch_r;
      p2_mode_nxt = p2_mode_r;
      p3_latch_nxt = p3_latch_r;
      p3_mode_nxt = p3_mode_r;
      pullup_dis_nxt = pullup_dis_r;
      input_en_nxt = input_en_r;
      sysclk_en_nxt = sysclk_en_r;
      if (sfr_req_i.wr) begin
         case (sfr_req_i.addr)
            `GP_ADDR_PORT0_PINS: p0_latch_nxt = sfr_req_i.wdata;
            `GP_ADDR_PORT0_MODE: p0_mode_nxt = sfr_req_i.wdata;
            `GP_ADDR_PORT2_PINS: p2_latch_nxt = sfr_req_i.wdata[5:0];
            `GP_ADDR_PORT2_MODE: p2_mode_nxt = sfr_req_i.wdata[5:0];
            `GP_ADDR_PORT3_PINS: p3_latch_nxt = sfr_req_i.wdata[0];
            `GP_ADDR_PORT3_MODE: p3_mode_nxt = sfr_req_i.wdata[0];
            `GP_ADDR_GLOBAL_CTL: begin
               pullup_dis_nxt = sfr_req_i.wdata[`GP_BIT_PULLUP_DIS];
               input_en_nxt = sfr_req_i.wdata[`GP_BIT_INPUT_EN];
               sysclk_en_nxt = sfr_req_i.wdata[`GP_BIT_SYSCLK_EN];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p0_latch_r <= `GP_RST_PINS;
         p0_mode_r <= `GP_RST_MODE;
         p2_latch_r <= 6'h3F;
         p2_mode_r <= 6'h00;
         p3_latch_r <= 1'b1;
         p3_mode_r <= 1'b0;
         pullup_dis_r <= 1'b0;
         input_en_r <= 1'b1;
         sysclk_en_r <= 1'b0;
      end else begin
         p0_latch_r <= p0_latch_nxt;
         p0_mode_r <= p0_mode_nxt;
         p2_latch_r <= p2_latch_nxt;
         p2_mode_r <= p2_mode_nxt;
         p3_latch_r <= p3_latch_nxt;
         p3_mode_r <= p3_mode_nxt;
         pullup_dis_r <= pullup_dis_nxt;
         input_en_r <= input_en_nxt;
         sysclk_en_r <= sysclk_en_nxt;
      end
   end

   // Pin sampling; gating with input enable models the disabled input path
   always_comb begin
      p0_sample_nxt = port0_pad_i & {8{input_en_r}};
      p2_sample_nxt = port2_pad_i & {6{input_en_r}};
      p3_sample_nxt = port3_pad_i & input_en_r;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p0_sample_r <= 8'h00;
         p2_sample_r <= 6'h00;
         p3_sample_r <= 1'b0;
      end else begin
         p0_sample_r <= p0_sample_nxt;
         p2_sample_r <= p2_sample_nxt;
         p3_sample_r <= p3_sample_nxt;
      end
   end

   // Plain reads see the pins, read-modify-write sees the latch
   always_comb begin
      p0_read = sfr_req_i.rmw ? p0_latch_r : (p0_sample_r & {8{input_en_r}});
      p2_read = {2'b00, sfr_req_i.rmw ? p2_latch_r : (p2_sample_r & {6{input_en_r}})};
      p3_read = {7'h00, sfr_req_i.rmw ? p3_latch_r : (p3_sample_r & input_en_r)};
   end

   always_comb begin
      rdata = 8'h00;
      hit = 1'b1;
      case (sfr_req_i.addr)
         `GP_ADDR_PORT0_PINS: rdata = p0_read;
         `GP_ADDR_PORT0_MODE: rdata = p0_mode_r;
         `GP_ADDR_PORT2_PINS: rdata = p2_read;
         `GP_ADDR_PORT2_MODE: rdata = {2'b00, p2_mode_r};
         `GP_ADDR_PORT3_PINS: rdata = p3_read;
         `GP_ADDR_PORT3_MODE: rdata = {7'h00, p3_mode_r};
         `GP_ADDR_GLOBAL_CTL: rdata = {pullup_dis_r, input_en_r, 5'h00, sysclk_en_r};
         default: hit = 1'b0;
      endcase
   end

   assign sfr_rdata_o = sfr_req_i.rd ? rdata : 8'h00;
   assign sfr_hit_o = hit & (sfr_req_i.rd | sfr_req_i.wr);
   assign sysclk_out_en_o = sysclk_en_r;

   gp_pin_cell #(.N(`GP_PORT0_WIDTH)) u_port0 (
      .latch_i(p0_latch_r),
      .push_pull_i(p0_mode_r),
      .pullup_dis_i(pullup_dis_r),
      .pad_o(port0_pad_o),
      .pad_oe_o(port0_pad_oe_o),
      .pullup_o(port0_pullup_o)
   );

   gp_pin_cell #(.N(`GP_PORT2_WIDTH)) u_port2 (
      .latch_i(p2_latch_r),
      .push_pull_i(p2_mode_r),
      .pullup_dis_i(pullup_dis_r),
      .pad_o(port2_pad_o),
      .pad_oe_o(port2_pad_oe_o),
      .pullup_o(port2_pullup_o)
   );

   gp_pin_cell #(.N(`GP_PORT3_WIDTH)) u_port3 (
      .latch_i(p3_latch_r),
      .push_pull_i(p3_mode_r),
      .pullup_dis_i(pullup_dis_r),
      .pad_o(port3_pad_o),
      .pad_oe_o(port3_pad_oe_o),
      .pullup_o(port3_pullup_o)
   );

endmodule : gp_ports

`default_nettype wire

// file: inc/gp_map.svh
/*
 Register offsets, field positions, reset values and widths for the port
 latch and drive mode block. Assumes an 8-bit special-function register bus.
*/
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

`define GP_ADDR_PORT0_PINS 8'h80
`define GP_ADDR_PORT0_MODE 8'hA4
`define GP_ADDR_PORT2_PINS 8'hA0
`define GP_ADDR_PORT2_MODE 8'hA6
`define GP_ADDR_PORT3_PINS 8'hB0
`define GP_ADDR_PORT3_MODE 8'hA7
`define GP_ADDR_GLOBAL_CTL 8'hF2

`define GP_RST_PINS 8'hFF
`define GP_RST_MODE 8'h00
`define GP_RST_GLOBAL_CTL 8'h40

`define GP_BIT_PULLUP_DIS 7
`define GP_BIT_INPUT_EN 6
`define GP_BIT_SYSCLK_EN 0

`define GP_PORT0_WIDTH 8
`define GP_PORT2_WIDTH 6
`define GP_PORT3_WIDTH 1

`endif

// file: inc/gp_pkg.sv
/*
 Types shared by the port block. Assumes gp_map.svh supplies the constants.
*/
package gp_pkg;

   typedef logic [7:0] gp_byte_t;

   // Special-function register bus request from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic rmw;
      logic [7:0] wdata;
   } gp_sfr_req_s;

endpackage : gp_pkg

// file: core/gp_pin_cell.sv
/*
 One port pin cell: drive, enable and weak pullup from latch and mode bit.
 Assumes the pad sums the enable, level and pullup into a wire level.
*/
`timescale 1ns/10ps
`default_nettype none

module gp_pin_cell #(
   parameter int N = 8
) (
   // Control
   input wire logic [N-1:0] latch_i,
   input wire logic [N-1:0] push_pull_i,
   input wire logic pullup_dis_i,
   // Pad
   output logic [N-1:0] pad_o,
   output logic [N-1:0] pad_oe_o,
   output logic [N-1:0] pullup_o
);

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cell
         // High level only driven in push-pull; open-drain floats on a one
         assign pad_o[g] = latch_i[g];
         assign pad_oe_o[g] = ~latch_i[g] | push_pull_i[g];
         assign pullup_o[g] = ~pullup_dis_i & ~push_pull_i[g] & latch_i[g];
      end
   endgenerate

endmodule : gp_pin_cell

`default_nettype wire

// file: testbench/gp_ports_monitor.sv
/* Checker for gp_ports pins and register bus.
 Bound to gp_ports; one clock, async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module gp_ports_monitor (
   // Clock and bus
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire gp_pkg::gp_sfr_req_s sfr_req_i,
   input wire logic [7:0] sfr_rdata_o,
   // Pins
   input wire logic [7:0] port0_pad_o,
   input wire logic [7:0] port0_pad_oe_o,
   input wire logic [7:0] port0_pullup_o,
   input wire logic [5:0] port2_pad_o,
   input wire logic [5:0] port2_pad_oe_o,
   input wire logic port3_pad_o,
   input wire logic port3_pad_oe_o
);
   import gp_pkg::*;
   logic [7:0] a, d;
   logic [5:0] d2;
   logic w, r, m;
   assign {a, w, r, m, d} = sfr_req_i;
   assign d2 = d[5:0];
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   a_latch_drive: assert property (w && a == 8'h80 |=> port0_pad_o == $past(d))
      else $error("port0 level differs from latch");
   a_p0_mode: assert property (w && a == 8'hA4 |=> port0_pad_oe_o == (~port0_pad_o | $past(d)))
      else $error("port0 enable wrong");
   a_p2_mode: assert property (w && a == 8'hA6 |=> port2_pad_oe_o == (~port2_pad_o | $past(d2)))
      else $error("port2 enable wrong");
   a_p3_mode: assert property (w && a == 8'hA7 |=> port3_pad_oe_o == (~port3_pad_o | $past(d2[0])))
      else $error("port3 enable wrong");
   a_pullup_gate: assert property ((port0_pullup_o & ~(port0_pad_o & ~port0_pad_oe_o)) == 8'h00)
      else $error("pullup on while driven or low");
   a_p2_unused: assert property (r && a == 8'hA6 |-> sfr_rdata_o[7:6] == 2'h0)
      else $error("port2 mode upper bits set");
   a_p3_unused: assert property (r && (a == 8'hB0 || a == 8'hA7) |-> sfr_rdata_o[7:1] == 7'h00)
      else $error("port3 upper bits set");
   a_input_off: assert property (w && a == 8'hF2 && !d[6] ##1 r && !m && a == 8'h80 |-> sfr_rdata_o == 8'h00)
      else $error("read not zero with inputs off");
   a_rmw_latch: assert property (w && a == 8'h80 ##1 r && m && a == 8'h80 |-> sfr_rdata_o == $past(d))
      else $error("rmw read not latch");
endmodule : gp_ports_monitor
bind gp_ports gp_ports_monitor mon_u (.mclk_i, .reset_n_i, .sfr_req_i, .sfr_rdata_o,
   .port0_pad_o, .port0_pad_oe_o, .port0_pullup_o, .port2_pad_o, .port2_pad_oe_o,
   .port3_pad_o, .port3_pad_oe_o);
`default_nettype wire

// file: testbench/gp_board.sv
/* Board model of one port: pad drive, weak pullup and an outside driver.
 Assumes the bench sets the outside driver; a floating pin toggles unless its pullup is on. */
`timescale 1ns/10ps
`default_nettype none
module gp_board #(
   parameter int N = 8
) (
   // Clock
   input wire logic mclk_i,
   // Device and outside drivers
   input wire logic [N-1:0] pad_i,
   input wire logic [N-1:0] oe_i,
   input wire logic [N-1:0] pullup_i,
   input wire logic [N-1:0] ext_en_i,
   input wire logic [N-1:0] ext_i,
   // Wire level
   output logic [N-1:0] level_o
);
   logic [N-1:0] pat_r = '0;
   // Undriven pin never holds a stable value the simulator could invent
   always_ff @(posedge mclk_i) pat_r <= ~pat_r;
   assign level_o = (oe_i & pad_i) | (~oe_i & ext_en_i & ext_i)
      | (~oe_i & ~ext_en_i & (pullup_i | pat_r));
endmodule : gp_board
`default_nettype wire

// file: testbench/gp_ports_tb.sv
/* Self-checking bench for gp_ports with board models on each port.
 Assumes combinational reads and writes taken at the next edge. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module gp_ports_tb;
   import gp_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   gp_sfr_req_s req = '0;
   logic [7:0] rdata, p0o, p0e, p0u, p0l;
   logic [5:0] p2o, p2e, p2u, p2l;
   logic p3o, p3e, p3u, p3l;
   logic hit, sck;
   // Outside drivers of the board; the bench moves them only at a rising edge
   logic [7:0] e0_en = 8'hFF, e0 = 8'h00;
   logic [5:0] e2_en = 6'h00, e2 = 6'h00;
   logic e3_en = 1'b0, e3 = 1'b0;
   int errors = 0;
   int checks = 0;
   always #5 mclk_i = ~mclk_i;
   gp_ports dut_u (.mclk_i, .reset_n_i, .sfr_req_i(req), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
      .port0_pad_i(p0l), .port0_pad_o(p0o), .port0_pad_oe_o(p0e), .port0_pullup_o(p0u),
      .port2_pad_i(p2l), .port2_pad_o(p2o), .port2_pad_oe_o(p2e), .port2_pullup_o(p2u),
      .port3_pad_i(p3l), .port3_pad_o(p3o), .port3_pad_oe_o(p3e), .port3_pullup_o(p3u),
      .sysclk_out_en_o(sck));
   // Port0 is held from outside wherever it floats, low first and high later
   gp_board #(.N(8)) b0_u (.mclk_i, .pad_i(p0o), .oe_i(p0e), .pullup_i(p0u),
      .ext_en_i(e0_en), .ext_i(e0), .level_o(p0l));
   gp_board #(.N(6)) b2_u (.mclk_i, .pad_i(p2o), .oe_i(p2e), .pullup_i(p2u),
      .ext_en_i(e2_en), .ext_i(e2), .level_o(p2l));
   gp_board #(.N(1)) b3_u (.mclk_i, .pad_i(p3o), .oe_i(p3e), .pullup_i(p3u),
      .ext_en_i(e3_en), .ext_i(e3), .level_o(p3l));
   // Kind 0 idle, 1 write, 2 read, 3 rmw read; held until the next call
   task automatic bus(input logic [7:0] a, input logic [1:0] k, input logic [7:0] d);
      @(posedge mclk_i);
      req <= '{a, k == 2'd1, k[1], k == 2'd3, d};
      @(negedge mclk_i);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 2'd1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
      bus(a, {1'b1, m}, 8'h00);
      `CHK(rdata, e)
   endtask : rd
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      #20000;
      errors++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rd(8'h80, 1'b1, 8'hFF);
      rd(8'hA4, 1'b0, 8'h00);
      rd(8'hA6, 1'b0, 8'h00);
      rd(8'hA7, 1'b0, 8'h00);
      rd(8'hB0, 1'b1, 8'h01);
      rd(8'hF2, 1'b0, 8'h40);
      `CHK(hit, 1'b1)
      `CHK(sck, 1'b0)
      `CHK(p0e, 8'h00)
      $display("test reset done");
      wr(8'h80, 8'h5A);
      rd(8'h80, 1'b1, 8'h5A);
      wr(8'hA4, 8'h0F);
      wr(8'hA6, 8'hFF);
      wr(8'hA7, 8'hFF);
      wr(8'hB0, 8'hFE);
      wr(8'hA0, 8'hEA);
      bus(8'h00, 2'd0, 8'h00);
      `CHK(p0o, 8'h5A)
      `CHK(p0e, 8'hAF)
      `CHK(p0u, 8'h50)
      `CHK(p2e, 6'h3F)
      `CHK(p2o, 6'h2A)
      `CHK({p3o, p3e}, 2'b01)
      rd(8'hA6, 1'b0, 8'h3F);
      rd(8'hB0, 1'b1, 8'h00);
      rd(8'hA0, 1'b1, 8'h2A);
      rd(8'hA0, 1'b0, 8'h2A);
      rd(8'h80, 1'b0, 8'h0A);
      // Released Port0 pins now held high from outside
      @(posedge mclk_i);
      e0 <= 8'hFF;
      rd(8'h80, 1'b0, 8'h5A);
      rd(8'h81, 1'b0, 8'h00);
      `CHK(hit, 1'b0)
      $display("test drive done");
      wr(8'hF2, 8'h00);
      rd(8'h80, 1'b0, 8'h00);
      rd(8'hA0, 1'b0, 8'h00);
      rd(8'hA0, 1'b1, 8'h2A);
      wr(8'hF2, 8'h41);
      wr(8'hA0, 8'hFF);
      wr(8'hA6, 8'h00);
      wr(8'hA7, 8'h00);
      wr(8'hB0, 8'hFF);
      bus(8'h00, 2'd0, 8'h00);
      `CHK(p2e, 6'h00)
      `CHK(p2u, 6'h3F)
      `CHK({p3e, p3u}, 2'b01)
      `CHK(sck, 1'b1)
      // Low four Port2 pins pulled down from outside, top two left to the pullups
      @(posedge mclk_i);
      e2_en <= 6'h0F;
      rd(8'hA0, 1'b0, 8'h30);
      rd(8'hB0, 1'b0, 8'h01);
      wr(8'hF2, 8'hFE);
      bus(8'h00, 2'd0, 8'h00);
      `CHK(p0u, 8'h00)
      `CHK(sck, 1'b0)
      rd(8'hF2, 1'b0, 8'hC0);
      $display("test float done");
      @(posedge mclk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rd(8'hF2, 1'b0, 8'h40);
      `CHK(p0o, 8'hFF)
      `CHK(p2o, 6'h3F)
      $display("test second reset done");
      finish_test();
   end
endmodule : gp_ports_tb
`default_nettype wire
